/* File: cbx_pkg.sv */
package cbx_pkg;

  // ****************************************
  // status word flag positions
  // ****************************************
  localparam int FLAG_ZERO = 0;
  localparam int FLAG_SIGN = 1;
  localparam int FLAG_OVERFLOW = 2;
  localparam int FLAG_CARRY = 3;
  localparam int FLAG_SATURATION = 4;

  // ****************************************
  // first-halfword opcode fields, bits 10..5; branch uses bits 10..7, table call bits 15..6
  // ****************************************
  localparam logic [5:0] OP_ADD_REG = 6'h0e;
  localparam logic [5:0] OP_ADD_IMM5 = 6'h12;
  localparam logic [5:0] OP_ADD_IMMEDIATE = 6'h30;
  localparam logic [5:0] OP_AND_REG = 6'h0a;
  localparam logic [5:0] OP_AND_IMMEDIATE = 6'h36;
  localparam logic [5:0] OP_COMPARE_REG = 6'h0f;
  localparam logic [5:0] OP_COMPARE_IMM5 = 6'h13;
  localparam logic [5:0] OP_EXTENDED = 6'h3f;
  localparam logic [3:0] OP_COND_BRANCH = 4'hb;
  localparam logic [9:0] OP_TABLE_CALL = 10'h008;

  // ****************************************
  // second-halfword codes of the extended group, and the return first halfword
  // ****************************************
  localparam logic [10:0] EXT_BYTE_SWAP_WORD = 11'h340;
  localparam logic [10:0] EXT_BYTE_SWAP_HALF = 11'h342;
  localparam logic [5:0] EXT_COND_MOVE_IMM = 6'h18;
  localparam logic [5:0] EXT_COND_MOVE_REG = 6'h19;
  localparam logic [15:0] RET_FIRST_HALF = 16'h07e0;
  localparam logic [15:0] RET_TABLE_CALL = 16'h0144;
  localparam logic [15:0] RET_DEBUG = 16'h0146;

  // ****************************************
  // execution cycle counts
  // ****************************************
  localparam logic [2:0] CYC_SIMPLE = 3'h1;
  localparam logic [2:0] CYC_BRANCH_TAKEN = 3'h2;
  localparam logic [2:0] CYC_BRANCH_NOT_TAKEN = 3'h1;
  localparam logic [2:0] CYC_RETURN = 3'h3;
  localparam logic [2:0] CYC_TABLE_CALL = 3'h4;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam int BUS_AW = 8;
  localparam logic [7:0] REG_PROG_COUNTER = 8'h00;
  localparam logic [7:0] REG_STATUS_WORD = 8'h04;
  localparam logic [7:0] REG_TABLE_BASE_PTR = 8'h08;
  localparam logic [7:0] REG_TABLE_RET_PC = 8'h0c;
  localparam logic [7:0] REG_TABLE_SAVED_STATUS = 8'h10;
  localparam logic [7:0] REG_DEBUG_RET_PC = 8'h14;
  localparam logic [7:0] REG_DEBUG_SAVED_STATUS = 8'h18;
  localparam logic [7:0] REG_EXEC_STATE = 8'h1c;
  localparam int GPR_WINDOW_BIT = 7;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] RST_PROG_COUNTER = 32'h0000_0000;
  localparam logic [31:0] RST_STATUS_WORD = 32'h0000_0000;
  localparam logic [31:0] RST_SAVE_REG = 32'h0000_0000;

  typedef enum logic [1:0] {ST_IDLE, ST_STALL, ST_MEM} cbx_state_e;

endpackage

/* File: cbx_cond_eval.sv */
`timescale 1ns/1ps
`default_nettype none

module cbx_cond_eval
  import cbx_pkg::*;
(
  input wire logic [3:0] condCode,
  input wire logic [31:0] statusWord,
  output logic condTrue
);

  logic carryFlag;
  logic overflowFlag;
  logic signFlag;
  logic zeroFlag;
  logic saturationFlag;
  logic baseTrue;

  // ****************************************
  // flag extraction
  // ****************************************
  assign carryFlag = statusWord[FLAG_CARRY];
  assign overflowFlag = statusWord[FLAG_OVERFLOW];
  assign signFlag = statusWord[FLAG_SIGN];
  assign zeroFlag = statusWord[FLAG_ZERO];
  assign saturationFlag = statusWord[FLAG_SATURATION];

  // base condition from the low three bits
  always_comb begin
    unique case (condCode[2:0])
      3'h0: baseTrue = overflowFlag; // [RULE_04]
      3'h1: baseTrue = carryFlag; // [RULE_04]
      3'h2: baseTrue = zeroFlag; // [RULE_05]
      3'h3: baseTrue = carryFlag | zeroFlag; // [RULE_05]
      3'h4: baseTrue = signFlag; // [RULE_05]
      3'h5: baseTrue = 1'b1; // [RULE_06]
      3'h6: baseTrue = signFlag ^ overflowFlag; // [RULE_06]
      3'h7: baseTrue = (signFlag ^ overflowFlag) | zeroFlag; // [RULE_06]
    endcase
  end

  // bit 3 negates, except 1101 which tests saturation
  assign condTrue = (condCode == 4'hd) ? saturationFlag : (baseTrue ^ condCode[3]); // [RULE_04] [RULE_06]

endmodule

`default_nettype wire

/* File: cbx_exec_core.sv */
// Functional notes
// [RULE_01] issue count spaces following different instructions
// [RULE_02] repeat count spaces same instruction back-to-back
// [RULE_03] latency stalls or forwards dependent results
// [RULE_04] codes 0/8 overflow, 1/9 carry; bit3 negates
// [RULE_05] codes 2/A zero, 3/B carry|zero, 4/C sign
// [RULE_06] 6/E S^OV, 7/F (S^OV)|Z, 5 always, D saturation
// [RULE_07] taken branch adds disp9, two cycles
// [RULE_08] untaken branch falls through, one cycle
// [RULE_09] cond_move picks imm/reg1 or reg2, flags kept
// [RULE_10] table_call saves pc+2 and status word
// [RULE_11] table_call loads halfword, jumps base+offset, four cycles
// [RULE_12] byte_swap_word reverses bytes, OV cleared
// [RULE_13] byte_swap_half swaps bytes per half
// [RULE_14] returns restore pc and status, three cycles
// [RULE_15] add/compare set four flags; and keeps carry
// [RULE_16] sign extension replicates msb to 32 bits
// [RULE_17] compare writes flags only, reg2 minus reg1
`timescale 1ns/1ps
`default_nettype none

module cbx_exec_core
  import cbx_pkg::*;
#(
  parameter int GPR_COUNT = 32
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic instrValid,
  input wire logic [31:0] instrWord,
  output logic instrReady,
  output logic retired,
  output logic [31:0] pcOut,
  output logic [31:0] statusOut,
  output logic memRdReq,
  output logic [31:0] memRdAddr,
  input wire logic [15:0] memRdData,
  input wire logic memRdAck,
  input wire logic [BUS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ****************************************
  // elaboration check
  // ****************************************
  if (GPR_COUNT != 32) begin : g_bad_count
    $error("cbx_exec_core: GPR_COUNT must be 32");
  end

  function automatic logic [31:0] readGpr(input logic [31:0] file [GPR_COUNT],
                                          input logic [4:0] idx);
    readGpr = (idx == 5'h00) ? 32'h0000_0000 : file[idx];
  endfunction

  logic [31:0] gprFile_r [GPR_COUNT];
  logic [31:0] pc_r, pc_nxt, psw_r, psw_nxt, tableBase_r, tableBase_nxt;
  logic [31:0] tableRetPc_r, tableRetPc_nxt, tableSaved_r, tableSaved_nxt;
  logic [31:0] debugRetPc_r, debugRetPc_nxt, debugSaved_r, debugSaved_nxt;
  cbx_state_e state_r, state_nxt;
  logic [2:0] stallCnt_r, stallCnt_nxt, execCycles;

  // ****************************************
  // instruction fields
  // ****************************************
  wire [15:0] hw0 = instrWord[15:0];
  wire [15:0] hw1 = instrWord[31:16];
  wire [4:0] reg1Idx = hw0[4:0];
  wire [4:0] reg2Idx = hw0[15:11];
  wire [4:0] reg3Idx = hw1[15:11];
  wire [31:0] gr1 = readGpr(gprFile_r, reg1Idx);
  wire [31:0] gr2 = readGpr(gprFile_r, reg2Idx);
  wire [31:0] imm5Sx = {{27{hw0[4]}}, hw0[4:0]}; // [RULE_16]
  wire [31:0] imm16Sx = {{16{hw1[15]}}, hw1}; // [RULE_16]
  wire [31:0] imm16Zx = {16'h0000, hw1};
  wire [31:0] disp9Sx = {{23{hw0[15]}}, hw0[15:11], hw0[6:4], 1'b0}; // [RULE_16]

  // ****************************************
  // decode
  // ****************************************
  wire isExt = (hw0[10:5] == OP_EXTENDED);
  wire isAddR = (hw0[10:5] == OP_ADD_REG);
  wire isAddI5 = (hw0[10:5] == OP_ADD_IMM5);
  wire isAddImmediate = (hw0[10:5] == OP_ADD_IMMEDIATE);
  wire isAndR = (hw0[10:5] == OP_AND_REG);
  wire isAndImmediate = (hw0[10:5] == OP_AND_IMMEDIATE);
  wire isCompareR = (hw0[10:5] == OP_COMPARE_REG);
  wire isCompareI5 = (hw0[10:5] == OP_COMPARE_IMM5);
  wire isCondBranch = (hw0[10:7] == OP_COND_BRANCH);
  wire isTableCall = (hw0[15:6] == OP_TABLE_CALL);
  wire isSwapWord = isExt && (hw1[10:0] == EXT_BYTE_SWAP_WORD);
  wire isSwapHalf = isExt && (hw1[10:0] == EXT_BYTE_SWAP_HALF);
  wire isCondMoveI = isExt && (hw1[10:5] == EXT_COND_MOVE_IMM) && !hw1[0];
  wire isCondMoveR = isExt && (hw1[10:5] == EXT_COND_MOVE_REG) && !hw1[0];
  wire isTableReturn = (hw0 == RET_FIRST_HALF) && (hw1 == RET_TABLE_CALL);
  wire isDebugReturn = (hw0 == RET_FIRST_HALF) && (hw1 == RET_DEBUG);
  wire isAdd = isAddR | isAddI5 | isAddImmediate;
  wire isCompare = isCompareR | isCompareI5;
  wire isAnd = isAndR | isAndImmediate;
  wire isLong = isExt | isAddImmediate | isAndImmediate;

  // ****************************************
  // condition test, shared by branch and move
  // ****************************************
  logic condTrue;
  wire [3:0] condSel = isCondBranch ? hw0[3:0] : hw1[4:1];

  cbx_cond_eval u_cond (
    .condCode(condSel),
    .statusWord(psw_r),
    .condTrue(condTrue)
  );

  // ****************************************
  // adder, subtract for compare
  // ****************************************
  wire [31:0] addA = isAddImmediate ? gr1 : gr2;
  wire [31:0] addB = (isAddR | isCompareR) ? gr1 : (isAddImmediate ? imm16Sx : imm5Sx);
  wire [31:0] addBop = isCompare ? ~addB : addB; // [RULE_17]
  wire [32:0] addFull = {1'b0, addA} + {1'b0, addBop} + {32'h0000_0000, isCompare};
  wire [31:0] addRes = addFull[31:0];
  wire addCarry = addFull[32] ^ isCompare; // borrow on compare
  wire addOverflow = (addA[31] == addBop[31]) && (addRes[31] != addA[31]);
  wire [31:0] andRes = isAndImmediate ? (gr1 & imm16Zx) : (gr2 & gr1);
  wire [31:0] swapWord = {gr2[7:0], gr2[15:8], gr2[23:16], gr2[31:24]}; // [RULE_12]
  wire [31:0] swapHalf = {gr2[23:16], gr2[31:24], gr2[7:0], gr2[15:8]}; // [RULE_13]
  wire swapWordCarry = (gr2[7:0] == 8'h00) | (gr2[15:8] == 8'h00) |
                       (gr2[23:16] == 8'h00) | (gr2[31:24] == 8'h00);
  wire swapHalfCarry = (gr2[15:0] == 16'h0000) | (gr2[31:16] == 16'h0000);
  wire [31:0] swapRes = isSwapWord ? swapWord : swapHalf;
  wire [31:0] moveRes = condTrue ? (isCondMoveI ? imm5Sx : gr1) : gr2; // [RULE_09]

  // ****************************************
  // result write and flag update
  // ****************************************
  logic gprWe;
  logic [4:0] gprWrIdx;
  logic [31:0] gprWrData, pswExec;
  wire accept = instrValid && instrReady;

  always_comb begin
    gprWe = 1'b0;
    gprWrIdx = reg2Idx;
    gprWrData = addRes;
    pswExec = psw_r;
    if (isAdd | isCompare) begin
      gprWe = isAdd; // [RULE_17]
      pswExec[FLAG_CARRY] = addCarry; // [RULE_15]
      pswExec[FLAG_OVERFLOW] = addOverflow;
      pswExec[FLAG_SIGN] = addRes[31];
      pswExec[FLAG_ZERO] = (addRes == 32'h0000_0000);
    end else if (isAnd) begin
      gprWe = 1'b1;
      gprWrData = andRes;
      pswExec[FLAG_OVERFLOW] = 1'b0; // [RULE_15]
      pswExec[FLAG_SIGN] = andRes[31];
      pswExec[FLAG_ZERO] = (andRes == 32'h0000_0000);
    end else if (isSwapWord | isSwapHalf) begin
      gprWe = 1'b1;
      gprWrIdx = reg3Idx;
      gprWrData = swapRes;
      pswExec[FLAG_CARRY] = isSwapWord ? swapWordCarry : swapHalfCarry; // [RULE_12] [RULE_13]
      pswExec[FLAG_OVERFLOW] = 1'b0;
      pswExec[FLAG_SIGN] = swapRes[31];
      pswExec[FLAG_ZERO] = (swapRes == 32'h0000_0000);
    end else if (isCondMoveI | isCondMoveR) begin
      gprWe = 1'b1; // [RULE_09]
      gprWrIdx = reg3Idx;
      gprWrData = moveRes;
    end
    gprWe = gprWe && accept && (gprWrIdx != 5'h00);
  end

  // cycles each instruction holds the issue slot
  always_comb begin
    if (isCondBranch) begin
      execCycles = condTrue ? CYC_BRANCH_TAKEN : CYC_BRANCH_NOT_TAKEN; // [RULE_07] [RULE_08]
    end else if (isTableReturn | isDebugReturn) begin
      execCycles = CYC_RETURN; // [RULE_14]
    end else if (isTableCall) begin
      execCycles = CYC_TABLE_CALL; // [RULE_11]
    end else begin
      execCycles = CYC_SIMPLE;
    end
  end

  // ****************************************
  // register bus decode
  // ****************************************
  wire busWrStb = avs_write && !avs_waitrequest;
  wire busGpr = avs_address[GPR_WINDOW_BIT];
  wire [4:0] busGprIdx = avs_address[6:2];
  wire [7:0] busReg = {avs_address[7:2], 2'b00};
  wire memDone = (state_r == ST_MEM) && memRdAck && memRdReq;
  logic [31:0] busRdData;

  always_comb begin
    busRdData = 32'h0000_0000;
    if (busGpr) begin
      busRdData = readGpr(gprFile_r, busGprIdx);
    end else begin
      unique case (busReg)
        REG_PROG_COUNTER: busRdData = pc_r;
        REG_STATUS_WORD: busRdData = psw_r;
        REG_TABLE_BASE_PTR: busRdData = tableBase_r;
        REG_TABLE_RET_PC: busRdData = tableRetPc_r;
        REG_TABLE_SAVED_STATUS: busRdData = tableSaved_r;
        REG_DEBUG_RET_PC: busRdData = debugRetPc_r;
        REG_DEBUG_SAVED_STATUS: busRdData = debugSaved_r;
        REG_EXEC_STATE: busRdData = {27'h0000000, memRdReq, stallCnt_r, instrReady};
        default: busRdData = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // architectural state, core wins over bus
  // ****************************************
  always_comb begin
    pc_nxt = pc_r;
    psw_nxt = psw_r;
    tableBase_nxt = tableBase_r;
    tableRetPc_nxt = tableRetPc_r;
    tableSaved_nxt = tableSaved_r;
    debugRetPc_nxt = debugRetPc_r;
    debugSaved_nxt = debugSaved_r;
    if (busWrStb && !busGpr) begin
      unique case (busReg)
        REG_PROG_COUNTER: pc_nxt = avs_writedata;
        REG_STATUS_WORD: psw_nxt = avs_writedata;
        REG_TABLE_BASE_PTR: tableBase_nxt = avs_writedata;
        REG_TABLE_RET_PC: tableRetPc_nxt = avs_writedata;
        REG_TABLE_SAVED_STATUS: tableSaved_nxt = avs_writedata;
        REG_DEBUG_RET_PC: debugRetPc_nxt = avs_writedata;
        REG_DEBUG_SAVED_STATUS: debugSaved_nxt = avs_writedata;
        default: pc_nxt = pc_r;
      endcase
    end
    if (accept) begin
      psw_nxt = pswExec;
      pc_nxt = pc_r + (isLong ? 32'h0000_0004 : 32'h0000_0002); // [RULE_08]
      if (isCondBranch && condTrue) begin
        pc_nxt = pc_r + disp9Sx; // [RULE_07]
      end else if (isTableCall) begin
        pc_nxt = pc_r;
        tableRetPc_nxt = pc_r + 32'h0000_0002; // [RULE_10]
        tableSaved_nxt = psw_r; // [RULE_10]
      end else if (isTableReturn) begin
        pc_nxt = tableRetPc_r; // [RULE_14]
        psw_nxt = tableSaved_r;
      end else if (isDebugReturn) begin
        pc_nxt = debugRetPc_r; // [RULE_14]
        psw_nxt = debugSaved_r;
      end
    end
    if (memDone) begin
      pc_nxt = tableBase_r + {16'h0000, memRdData}; // [RULE_11]
    end
  end

  // ****************************************
  // issue control: stall until the slot frees
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    stallCnt_nxt = stallCnt_r;
    unique case (state_r)
      ST_IDLE: begin
        if (accept) begin
          stallCnt_nxt = execCycles - 3'h1; // [RULE_01] [RULE_02]
          if (isTableCall) begin
            state_nxt = ST_MEM;
          end else if (execCycles > 3'h1) begin
            state_nxt = ST_STALL;
          end
        end
      end
      ST_STALL: begin
        stallCnt_nxt = stallCnt_r - 3'h1;
        if (stallCnt_r == 3'h1) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_MEM: begin
        if (stallCnt_r != 3'h0) begin
          stallCnt_nxt = stallCnt_r - 3'h1;
        end
        if (memDone) begin
          state_nxt = (stallCnt_r > 3'h1) ? ST_STALL : ST_IDLE; // [RULE_11]
        end
      end
    endcase
  end

  // state flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      stallCnt_r <= 3'h0;
      instrReady <= 1'b0;
      retired <= 1'b0;
    end else begin
      state_r <= state_nxt;
      stallCnt_r <= stallCnt_nxt;
      instrReady <= (state_nxt == ST_IDLE); // [RULE_01] [RULE_02]
      retired <= accept;
    end
  end

  // architectural register flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pc_r <= RST_PROG_COUNTER;
      psw_r <= RST_STATUS_WORD;
      tableBase_r <= RST_SAVE_REG;
      tableRetPc_r <= RST_SAVE_REG;
      tableSaved_r <= RST_SAVE_REG;
      debugRetPc_r <= RST_SAVE_REG;
      debugSaved_r <= RST_SAVE_REG;
    end else begin
      pc_r <= pc_nxt;
      psw_r <= psw_nxt;
      tableBase_r <= tableBase_nxt;
      tableRetPc_r <= tableRetPc_nxt;
      tableSaved_r <= tableSaved_nxt;
      debugRetPc_r <= debugRetPc_nxt;
      debugSaved_r <= debugSaved_nxt;
    end
  end

  assign pcOut = pc_r;
  assign statusOut = psw_r;

  // register file, result visible to the very next issue
  always_ff @(posedge core_clk) begin
    if (gprWe) begin
      gprFile_r[gprWrIdx] <= gprWrData; // [RULE_03]
    end else if (busWrStb && busGpr) begin
      gprFile_r[busGprIdx] <= avs_writedata;
    end
  end

  // halfword fetch for the table call
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      memRdReq <= 1'b0;
      memRdAddr <= 32'h0000_0000;
    end else if (accept && isTableCall) begin
      memRdReq <= 1'b1;
      memRdAddr <= tableBase_r + {25'h0000000, hw0[5:0], 1'b0}; // [RULE_11]
    end else if (memDone) begin
      memRdReq <= 1'b0;
    end
  end

  // ****************************************
  // bus answer: one wait cycle per access
  // ****************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !((avs_read | avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= busRdData;
      end
    end
  end

endmodule

`default_nettype wire

/* File: cbx_exec_core_props.sv */
`timescale 1ns/1ps
`default_nettype none

// ******
// port checker
// ******
module cbx_exec_core_props
  import cbx_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic instrValid,
  input wire logic [31:0] instrWord,
  input wire logic instrReady,
  input wire logic retired,
  input wire logic [31:0] pcOut,
  input wire logic memRdReq,
  input wire logic [31:0] memRdAddr,
  input wire logic memRdAck,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  default clocking cbClk @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // decode helpers for the antecedents
  wire logic take = instrValid && instrReady;
  wire logic busReq = avs_read || avs_write;
  wire logic isCall = instrWord[15:6] == OP_TABLE_CALL;
  wire logic isAdd = instrWord[10:5] == OP_ADD_REG;
  wire logic isRet = instrWord == {RET_TABLE_CALL, RET_FIRST_HALF} ||
                     instrWord == {RET_DEBUG, RET_FIRST_HALF};
  wire logic isAlways = instrWord[10:7] == OP_COND_BRANCH && instrWord[3:0] == 4'h5;
  wire logic [31:0] brDisp = {{23{instrWord[15]}}, instrWord[15:11], instrWord[6:4], 1'h0};

  // stall shapes after a take
  sequence sHold1;
    !instrReady ##1 instrReady;
  endsequence
  sequence sHold3;
    !instrReady [*2] ##1 instrReady;
  endsequence

  // bus handshake
  a_bus_answer: assert property (busReq && avs_waitrequest |=> !avs_waitrequest)
    else $error("no bus answer");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_idle: assert property (!busReq && avs_waitrequest |=> avs_waitrequest)
    else $error("stray answer");

  // issue and retire timing
  a_retire_take: assert property (take |=> retired)
    else $error("no retire");
  a_retire_quiet: assert property (!take |=> !retired)
    else $error("stray retire");
  a_add_single: assert property (take && isAdd |=> instrReady)
    else $error("add stalled");
  a_branch_always: assert property (take && isAlways |=>
    (pcOut == $past(pcOut) + $past(brDisp)) ##0 sHold1)
    else $error("branch wrong");
  a_return_stall: assert property (take && isRet |=> sHold3)
    else $error("return timing");

  // table call memory read
  a_call_request: assert property (take && isCall |=>
    (memRdReq && !instrReady) ##1 !instrReady [*2])
    else $error("call timing");
  a_mem_hold: assert property (memRdReq && !memRdAck |=> memRdReq && $stable(memRdAddr))
    else $error("read not held");
  a_mem_release: assert property (memRdReq && memRdAck |=> !memRdReq)
    else $error("read not released");
endmodule

bind cbx_exec_core cbx_exec_core_props chk_u (
  .core_clk,
  .resetn,
  .instrValid,
  .instrWord,
  .instrReady,
  .retired,
  .pcOut,
  .memRdReq,
  .memRdAddr,
  .memRdAck,
  .avs_read,
  .avs_write,
  .avs_waitrequest
);

`default_nettype wire

/* File: cbx_exec_core_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

// ******
// core bench
// ******
module cbx_exec_core_tb_top
  import cbx_pkg::*;
;
  logic core_clk;
  logic resetn;
  logic instrValid;
  logic [31:0] instrWord;
  logic instrReady;
  logic retired;
  logic [31:0] pcOut;
  logic [31:0] statusOut;
  logic memRdReq;
  logic [31:0] memRdAddr;
  logic [15:0] memRdData = 16'h5a5a;
  logic memRdAck = 1'h0;
  logic [BUS_AW-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] rdv;
  logic [31:0] memAddrSeen;
  logic [15:0] memHalf;
  int fail_count;
  int n_compared;
  int memDelay;
  int memWait = 0;
  int cyc;

  cbx_exec_core dut_u (
    .core_clk,
    .resetn,
    .instrValid,
    .instrWord,
    .instrReady,
    .retired,
    .pcOut,
    .statusOut,
    .memRdReq,
    .memRdAddr,
    .memRdData,
    .memRdAck,
    .avs_address,
    .avs_read,
    .avs_write,
    .avs_writedata,
    .avs_readdata,
    .avs_waitrequest
  );

  // 100 MHz core clock
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // table memory, answers after memDelay cycles
  always @(posedge core_clk) begin
    if (memRdReq && !memRdAck && memWait == memDelay) begin
      memRdAck <= 1'h1;
      memRdData <= memHalf;
      memAddrSeen <= memRdAddr;
      memWait <= 0;
    end else begin
      memRdAck <= 1'h0;
      memRdData <= ~memRdData;
      if (memRdReq && !memRdAck) memWait <= memWait + 1;
    end
  end

  // ******
  // reporting
  // ******
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // ******
  // drivers
  // ******
  task automatic busOp(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    int n = 0;
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= adr;
    avs_writedata <= wd;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 50);
    rdv = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (n >= 50) begin
      fail_count++;
      results();
    end
    @(posedge core_clk);
  endtask

  task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp);
    busOp(1'h0, adr, 32'h0);
    chk(rdv, exp);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    busOp(1'h1, adr, wd);
  endtask

  // offer one instruction, count busy cycles
  task automatic issue(input logic [31:0] w);
    int n = 0;
    instrValid <= 1'h1;
    instrWord <= w;
    do begin
      @(posedge core_clk);
      n++;
    end while (instrReady !== 1'h1 && n < 50);
    instrValid <= 1'h0;
    cyc = 1;
    @(posedge core_clk);
    while (instrReady !== 1'h1 && cyc < 50) begin
      cyc++;
      @(posedge core_clk);
    end
    if (n >= 50 || cyc >= 50) begin
      fail_count++;
      results();
    end
  endtask

  // expected truth of a condition code; flags are {sat, cy, ov, s, z}
  function automatic logic condOk(input logic [3:0] c, input logic [4:0] f);
    logic b;
    case (c[2:0])
      3'h0: b = f[2];
      3'h1: b = f[3];
      3'h2: b = f[0];
      3'h3: b = f[3] | f[0];
      3'h4: b = f[1];
      3'h5: b = c[3] ? !f[4] : 1'h1;
      3'h6: b = f[1] ^ f[2];
      default: b = (f[1] ^ f[2]) | f[0];
    endcase
    return b ^ c[3];
  endfunction

  // ******
  // scenarios
  // ******
  task automatic t_reset();
    chk(pcOut, 32'h0);
    chk(statusOut, 32'h0);
    rdChk(REG_EXEC_STATE, 32'h1);
    wr(REG_EXEC_STATE, 32'hff);
    rdChk(REG_EXEC_STATE, 32'h1);
    wr(8'h20, 32'h1234);
    rdChk(8'h20, 32'h0);
    wr(8'h80, 32'h55);
    rdChk(8'h80, 32'h0);
  endtask

  // all codes, four flag patterns
  task automatic t_cond();
    logic [4:0] pat;
    logic [15:0] w;
    logic [31:0] d;
    logic tk;
    for (int p = 0; p < 4; p++) begin
      pat = (p == 0) ? 5'h00 : (p == 1) ? 5'h1f : (p == 2) ? 5'h15 : 5'h0a;
      for (int c = 0; c < 16; c++) begin
        w = {c[0] ? 5'h1f : 5'h00, 4'hb, c[0] ? 3'h6 : 3'h4, c[3:0]};
        d = c[0] ? 32'hffff_fffc : 32'h8;
        wr(REG_STATUS_WORD, {27'h0, pat});
        wr(REG_PROG_COUNTER, 32'h100);
        issue({16'h0, w});
        tk = condOk(c[3:0], pat);
        chk(pcOut, tk ? 32'h100 + d : 32'h102);
        chk(32'(cyc), tk ? 32'h2 : 32'h1);
      end
    end
  endtask

  // add, compare, and; dependent back to back
  task automatic t_alu();
    wr(8'h84, 32'h7fff_ffff);
    wr(8'h88, 32'h1);
    wr(8'h8c, 32'hffff_ffff);
    wr(8'h90, 32'h1);
    issue({16'h0, 5'h2, OP_ADD_REG, 5'h1});
    chk(statusOut, 32'h6);
    issue({16'h0, 5'h4, OP_ADD_REG, 5'h3});
    chk(statusOut, 32'h9);
    issue({16'h0, 5'h4, OP_COMPARE_IMM5, 5'h1f});
    chk(statusOut, 32'h8);
    issue({16'h0, 5'h2, OP_COMPARE_REG, 5'h1});
    chk(statusOut, 32'h4);
    rdChk(8'h88, 32'h8000_0000);
    wr(REG_STATUS_WORD, 32'hc);
    issue({16'h0, 5'h2, OP_AND_REG, 5'h1});
    chk(statusOut, 32'h9);
    rdChk(8'h88, 32'h0);
  endtask

  task automatic t_cond_move();
    wr(8'h94, 32'h1111_1111);
    wr(8'h98, 32'h2222_2222);
    wr(REG_STATUS_WORD, 32'h1);
    issue({5'h7, EXT_COND_MOVE_REG, 4'h2, 1'h0, 5'h6, OP_EXTENDED, 5'h5});
    rdChk(8'h9c, 32'h1111_1111);
    issue({5'h7, EXT_COND_MOVE_REG, 4'ha, 1'h0, 5'h6, OP_EXTENDED, 5'h5});
    rdChk(8'h9c, 32'h2222_2222);
    issue({5'h7, EXT_COND_MOVE_IMM, 4'h5, 1'h0, 5'h6, OP_EXTENDED, 5'h1e});
    chk(32'(cyc), 32'h1);
    rdChk(8'h9c, 32'hffff_fffe);
    chk(statusOut, 32'h1);
  endtask

  task automatic t_swap();
    wr(8'ha0, 32'h00ff_8001);
    wr(REG_STATUS_WORD, 32'h4);
    issue({5'h9, EXT_BYTE_SWAP_WORD, 5'h8, OP_EXTENDED, 5'h0});
    chk(statusOut, 32'h8);
    rdChk(8'ha4, 32'h0180_ff00);
    wr(8'ha0, 32'h80ff_0012);
    wr(REG_STATUS_WORD, 32'h4);
    issue({5'h9, EXT_BYTE_SWAP_HALF, 5'h8, OP_EXTENDED, 5'h0});
    chk(statusOut, 32'h2);
    rdChk(8'ha4, 32'hff80_1200);
  endtask

  // table call, prompt and slow memory
  task automatic t_call();
    wr(REG_TABLE_BASE_PTR, 32'h1000);
    wr(REG_PROG_COUNTER, 32'h200);
    wr(REG_STATUS_WORD, 32'h13);
    memDelay = 0;
    memHalf = 16'h8040;
    issue({16'h0, OP_TABLE_CALL, 6'h05});
    chk(memAddrSeen, 32'h100a);
    chk(pcOut, 32'h9040);
    chk(32'(cyc), 32'h4);
    rdChk(REG_TABLE_RET_PC, 32'h202);
    rdChk(REG_TABLE_SAVED_STATUS, 32'h13);
    memDelay = 5;
    memHalf = 16'h0010;
    issue({16'h0, OP_TABLE_CALL, 6'h3f});
    chk(memAddrSeen, 32'h107e);
    chk(pcOut, 32'h1010);
    chk(32'(cyc > 4), 32'h1);
  endtask

  task automatic t_ret();
    wr(REG_TABLE_RET_PC, 32'h3456);
    wr(REG_TABLE_SAVED_STATUS, 32'h1b);
    wr(REG_DEBUG_RET_PC, 32'h7772);
    wr(REG_DEBUG_SAVED_STATUS, 32'h5);
    issue({RET_TABLE_CALL, RET_FIRST_HALF});
    chk(pcOut, 32'h3456);
    chk(statusOut, 32'h1b);
    chk(32'(cyc), 32'h3);
    issue({RET_DEBUG, RET_FIRST_HALF});
    chk(pcOut, 32'h7772);
    chk(statusOut, 32'h5);
  endtask

  // main sequence
  initial begin
    resetn = 1'h0;
    instrValid = 1'h0;
    instrWord = 32'h0;
    avs_address = 8'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    memHalf = 16'h0;
    memDelay = 0;
    fail_count = 0;
    n_compared = 0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'h1;
    @(posedge core_clk);
    t_reset();
    t_cond();
    t_alu();
    t_cond_move();
    t_swap();
    t_call();
    t_ret();
    results();
  end
endmodule

`default_nettype wire
